// file: inc/csb_if.sv
// Interface joining the processor end and the agent end.
// Resolves the shared buses itself, from the processor enable alone.
`timescale 1ns/1ps
`default_nettype none
interface csb_if;
    logic [63:0] cpuAddrData;
    logic [8:0] cpuCommand;
    logic cpuBusOe;
    logic [63:0] agentAddrData;
    logic [8:0] agentCommand;
    logic agentBusOe;
    logic cpu_valid_strobe_n;
    logic agent_valid_strobe_n;
    logic read_ready_n;
    logic write_ready_n;
    logic agent_bus_request_n;
    logic bus_grant_n;
    wire [63:0] addr_data_bus = cpuBusOe ? cpuAddrData : agentAddrData;
    wire [8:0] command_bus = cpuBusOe ? cpuCommand : agentCommand;

    modport cpu (
        output cpuAddrData, cpuCommand, cpuBusOe, cpu_valid_strobe_n,
        output bus_grant_n,
        input agentAddrData, agentCommand, agentBusOe,
        input agent_valid_strobe_n, read_ready_n, write_ready_n,
        input agent_bus_request_n
    );
    modport agent (
        output agentAddrData, agentCommand, agentBusOe,
        output agent_valid_strobe_n, read_ready_n, write_ready_n,
        output agent_bus_request_n,
        input cpuAddrData, cpuCommand, cpuBusOe, cpu_valid_strobe_n,
        input bus_grant_n
    );
endinterface
`default_nettype wire

// file: inc/csb_pkg.sv
// Shared constants and types for the processor system bus handshake.
// Assumes both ends run on one 250 MHz clock and a shared reset.
`default_nettype none
package csb_pkg;
    localparam int ADDR_DATA_W = 64;
    localparam int CMD_W = 9;
    localparam int CMD_KIND_BIT = 8;          // 0 address cycle, 1 data cycle
    localparam int READY_LEAD_CYCLES = 2;     // Ready sampled this early
    localparam int WRITE_GAP_CYCLES = 4;      // Legacy write spacing
    localparam logic [7:0] DATA_ID_LAST = 8'h80;
    localparam logic [7:0] DATA_ID_ERROR = 8'h20;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_WRITE = 8'h80;
    localparam logic [2:0] GAP_RESET = 3'h0;
    localparam logic [2:0] WDATA_RESET = 3'h0;

    typedef enum logic [2:0] {
        CSB_IDLE = 3'b000,
        CSB_ADDR = 3'b001,
        CSB_WDATA = 3'b011,
        CSB_RWAIT = 3'b010,
        CSB_SLAVE = 3'b110,
        CSB_GAP = 3'b111
    } csb_cpu_state_type;
endpackage
`default_nettype wire

// file: rtl/csb_agent_end.sv
// External agent end: ready throttling, bus request, read responses.
// Assumes the processor end follows the handshake on the same clock.
`timescale 1ns/1ps
`default_nettype none
module csb_agent_end
    import csb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    csb_if.agent bus,
    input wire logic canRead,
    input wire logic canWrite,
    input wire logic extReqValid,
    input wire logic [63:0] extReqAddr,
    input wire logic [63:0] respData,
    input wire logic respError,
    output logic extReqDone,
    output logic cpuReqValid,
    output logic [63:0] cpuReqWord,
    output logic [8:0] cpuReqCmd
);
    import csb_pkg::*;

    logic slave_q, wantBus_q, readOwed_q, sentAddr_q, grantSeen;
    logic [1:0] rdyHist_q;

    assign grantSeen = !bus.bus_grant_n;

    // Ownership tracking and external request sequence
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slave_q <= 1'b0;
            wantBus_q <= 1'b0;
            readOwed_q <= 1'b0;
            sentAddr_q <= 1'b0;
            extReqDone <= 1'b0;
            rdyHist_q <= 2'h0;
        end else begin
            extReqDone <= 1'b0;
            // Own read-ready pin history, to spot the issued address
            rdyHist_q <= {rdyHist_q[0], !bus.read_ready_n};
            // No new ask in the cycle that reports the last one done
            if (!slave_q && extReqValid && !extReqDone) begin
                wantBus_q <= 1'b1; // Ask for bus
            end
            if (!bus.cpu_valid_strobe_n && !bus.cpuCommand[CMD_KIND_BIT] &&
                bus.cpuCommand[7:0] == CMD_READ && rdyHist_q[1]) begin
                readOwed_q <= 1'b1;
            end
            if (grantSeen) begin
                slave_q <= 1'b1; // Drive only after grant
                wantBus_q <= 1'b0;
            end else if (slave_q) begin
                if (wantBus_q || extReqValid) begin
                    sentAddr_q <= !sentAddr_q;
                    if (sentAddr_q) begin
                        slave_q <= 1'b0;
                        extReqDone <= 1'b1;
                    end
                end else if (readOwed_q) begin
                    slave_q <= 1'b0; // Response word ends the read
                    readOwed_q <= 1'b0;
                end
            end
        end
    end

    // Registered pins toward the processor
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.agentAddrData <= '0;
            bus.agentCommand <= '0;
            bus.agentBusOe <= 1'b0;
            bus.agent_valid_strobe_n <= 1'b1;
            bus.read_ready_n <= 1'b1;
            bus.write_ready_n <= 1'b1;
            bus.agent_bus_request_n <= 1'b1;
        end else begin
            bus.read_ready_n <= !(canRead && !readOwed_q);
            bus.write_ready_n <= !canWrite;
            bus.agent_bus_request_n <= !(wantBus_q && !slave_q);
            bus.agentBusOe <= slave_q && !(extReqDone);
            bus.agent_valid_strobe_n <= 1'b1;
            if (slave_q && (extReqValid || wantBus_q)) begin
                bus.agent_valid_strobe_n <= 1'b0;
                bus.agentAddrData <= sentAddr_q ? respData : extReqAddr;
                bus.agentCommand <= sentAddr_q ? {1'b1, DATA_ID_LAST} :
                    {1'b0, CMD_WRITE};
            end else if (slave_q && readOwed_q) begin
                bus.agent_valid_strobe_n <= 1'b0;
                bus.agentAddrData <= respData;
                bus.agentCommand <= {1'b1, DATA_ID_LAST |
                    (respError ? DATA_ID_ERROR : 8'h00)};
            end
        end
    end

    // Captured processor cycles for the user side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpuReqValid <= 1'b0;
            cpuReqWord <= '0;
            cpuReqCmd <= '0;
        end else begin
            cpuReqValid <= !bus.cpu_valid_strobe_n;
            cpuReqWord <= bus.cpuAddrData;
            cpuReqCmd <= bus.cpuCommand;
        end
    end
endmodule
`default_nettype wire

// file: rtl/csb_cpu_end.sv
// Processor end of the system bus: request issue, arbitration, slave state.
// Summary of operation
// - Agent read/write ready gate own request type.
// - Agent requests bus; processor answers with grant.
// - All pins registered on rising clock edge.
// - Processor strobes valid on each driven cycle.
// - Agent strobes valid on each driven cycle.
// - Master state except granted or self-released.
// - Agent issues requests only in slave state.
// - Request, then release with one-cycle grant.
// - Return to master when external request ends.
// - Pending read: grant one cycle after issue.
// - Self-release ends with next last-tagged agent data word.
// - Agent drives only after seeing slave state.
// - No new read until response received.
// - Legacy mode: four idle cycles after writes.
// - One request at a time; writes without reads.
// - Read ends on last word; agent may interleave, but its own last word also ends the read.
// - Read pending until data; error id flagged.
// - Agent accepts reads under read-ready rule.
// - Write complete after last data word.
// - Agent accepts writes under write-ready rule.
// - Command top bit marks address or data.
// - Repeat address until ready two cycles prior.
// Assumes the agent follows the handshake; pins come from another chip.
`timescale 1ns/1ps
`default_nettype none
module csb_cpu_end
    import csb_pkg::*;
#(
    parameter int WRITE_WORDS = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    csb_if.cpu bus,
    input wire logic legacyMode,
    input wire logic reqValid,
    input wire logic reqIsWrite,
    input wire logic [63:0] reqAddr,
    input wire logic [63:0] reqWriteData,
    output logic reqReady,
    output logic readDoneValid,
    output logic [63:0] readData,
    output logic busError
);
    import csb_pkg::*;

    csb_cpu_state_type state_q;
    logic legacySync;
    logic rdRdyIn_q, wrRdyIn_q, extReqIn_q, agent_valid_strobe_n_q;
    logic [63:0] adIn_q;
    logic [8:0] cmdIn_q;
    logic isWrite_q, readPending_q, extActive_q, resume_q;
    logic [63:0] addr_q, wdata_q;
    logic [2:0] gap_q, wcount_q;
    logic readyOk, extEnd;

    // Static mode strap comes from outside the clock domain
    csb_sync3 #(.RESET_VAL(1'b0)) syncLegacy (.clk(clk), .arst_n(arst_n),
        .async_in(legacyMode), .sync_out(legacySync));

    // Agent pins share our clock: one input register each
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            adIn_q <= '0;
            cmdIn_q <= '0;
            agent_valid_strobe_n_q <= 1'b0;
            extReqIn_q <= 1'b0;
            rdRdyIn_q <= 1'b0;
            wrRdyIn_q <= 1'b0;
        end else begin
            adIn_q <= bus.agentAddrData;
            cmdIn_q <= bus.agentCommand;
            agent_valid_strobe_n_q <= !bus.agent_valid_strobe_n;
            extReqIn_q <= !bus.agent_bus_request_n;
            rdRdyIn_q <= !bus.read_ready_n;
            wrRdyIn_q <= !bus.write_ready_n;
        end
    end

    // Ready pin two cycles before the address pin cycle
    assign readyOk = isWrite_q ? wrRdyIn_q : rdRdyIn_q;
    // An external request ends on a valid data cycle tagged last
    assign extEnd = agent_valid_strobe_n_q && cmdIn_q[CMD_KIND_BIT] &&
        ((cmdIn_q[7:0] & DATA_ID_LAST) != 8'h00);

    // Bus ownership and request sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CSB_IDLE;
            isWrite_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            gap_q <= GAP_RESET;
            wcount_q <= WDATA_RESET;
            readPending_q <= 1'b0;
            extActive_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            unique case (state_q)
                CSB_IDLE: begin
                    if (extReqIn_q) begin
                        state_q <= CSB_SLAVE; // Grant on request
                        extActive_q <= 1'b1;
                    end else if (reqValid && !readPending_q) begin
                        state_q <= CSB_ADDR; // One at a time
                        isWrite_q <= reqIsWrite;
                        addr_q <= reqAddr;
                        wdata_q <= reqWriteData;
                    end
                end
                CSB_ADDR: begin
                    if (readyOk) begin
                        if (isWrite_q) begin
                            state_q <= CSB_WDATA;
                            wcount_q <= WDATA_RESET;
                        end else begin
                            state_q <= CSB_RWAIT; // Read issued
                            readPending_q <= 1'b1;
                        end
                    end else if (extReqIn_q) begin
                        state_q <= CSB_SLAVE; // Release before issue
                        extActive_q <= 1'b1;
                        resume_q <= 1'b1;
                    end
                end
                CSB_WDATA: begin
                    if (wcount_q == 3'(WRITE_WORDS - 1)) begin
                        // Write complete after last word
                        state_q <= legacySync ? CSB_GAP : CSB_IDLE;
                        gap_q <= GAP_RESET;
                    end else begin
                        wcount_q <= wcount_q + 3'h1;
                    end
                end
                CSB_GAP: begin
                    // Legacy spacing after write issue
                    if (gap_q == 3'(WRITE_GAP_CYCLES - 2)) begin
                        state_q <= CSB_IDLE;
                    end else begin
                        gap_q <= gap_q + 3'h1;
                    end
                end
                CSB_RWAIT: begin
                    state_q <= CSB_SLAVE; // Self release
                end
                CSB_SLAVE: begin
                    if (extEnd) begin
                        // Back to master at request end
                        extActive_q <= 1'b0;
                        resume_q <= 1'b0;
                        if (readPending_q && !extActive_q) begin
                            readPending_q <= 1'b0;
                        end
                        // Held request retries its address cycle
                        state_q <= resume_q ? CSB_ADDR : CSB_IDLE;
                    end
                end
                default: state_q <= CSB_IDLE;
            endcase
        end
    end

    // Output registers toward the agent
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.cpuAddrData <= '0;
            bus.cpuCommand <= '0;
            bus.cpuBusOe <= 1'b1;
            bus.cpu_valid_strobe_n <= 1'b1;
            bus.bus_grant_n <= 1'b1;
        end else begin
            bus.cpuBusOe <= (state_q != CSB_SLAVE);
            bus.cpu_valid_strobe_n <= !(state_q == CSB_ADDR ||
                state_q == CSB_WDATA);
            bus.bus_grant_n <= 1'b1;
            if (state_q == CSB_ADDR) begin
                bus.cpuAddrData <= addr_q; // Repeated until issue
                bus.cpuCommand <= {1'b0, isWrite_q ? CMD_WRITE : CMD_READ};
            end else if (state_q == CSB_WDATA) begin
                bus.cpuAddrData <= wdata_q;
                bus.cpuCommand <= {1'b1,
                    wcount_q == 3'(WRITE_WORDS - 1) ? DATA_ID_LAST : 8'h00};
            end
            if ((state_q == CSB_IDLE || state_q == CSB_ADDR) && extReqIn_q &&
                !(state_q == CSB_ADDR && readyOk)) begin
                bus.bus_grant_n <= 1'b0; // One-cycle grant
            end
            if (state_q == CSB_RWAIT) begin
                bus.bus_grant_n <= 1'b0;
            end
        end
    end

    // User-side results
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reqReady <= 1'b0;
            readDoneValid <= 1'b0;
            readData <= '0;
            busError <= 1'b0;
        end else begin
            reqReady <= (state_q == CSB_IDLE) && !readPending_q;
            readDoneValid <= 1'b0;
            busError <= 1'b0;
            if (state_q == CSB_SLAVE && readPending_q && !extActive_q &&
                agent_valid_strobe_n_q && cmdIn_q[CMD_KIND_BIT]) begin
                readData <= adIn_q;
                readDoneValid <= extEnd;
                // Error identifier becomes a bus error
                busError <= (cmdIn_q[7:0] & DATA_ID_ERROR) != 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/csb_sync3.sv
// Three-stage synchroniser; change accepted when stages two and three agree.
// Assumes an asynchronous input and a constant reset value.
`timescale 1ns/1ps
`default_nettype none
module csb_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q, s2_q, s3_q;

    // Stage chain and agreement filter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/csb_bus_props.sv
// Property checker for the bus between the processor and agent ends.
// Assumes one clock domain; sees the interface signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module csb_bus_props
    import csb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [8:0] cpuCommand,
    input wire logic cpuBusOe,
    input wire logic [8:0] agentCommand,
    input wire logic agentBusOe,
    input wire logic cpu_valid_strobe_n,
    input wire logic agent_valid_strobe_n,
    input wire logic bus_grant_n
);
    logic readAddr;
    logic readAddrQ;
    logic pendingQ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Read address cycle on the wire
    assign readAddr = !cpu_valid_strobe_n && cpuCommand == {1'b0, CMD_READ};
    // Read address seen one cycle ago
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readAddrQ <= 1'b0;
        end else begin
            readAddrQ <= readAddr;
        end
    end
    // Read outstanding from its grant to a last-tagged agent data cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pendingQ <= 1'b0;
        end else if (!agent_valid_strobe_n && agentCommand[8]
                && agentCommand[7]) begin
            pendingQ <= 1'b0;
        end else if (readAddrQ && !bus_grant_n) begin
            pendingQ <= 1'b1;
        end
    end
    property p_grant_pulse;
        $fell(bus_grant_n) |=> bus_grant_n;
    endproperty
    a_grant_pulse: assert property (p_grant_pulse)
        else $error("grant longer than one cycle");
    property p_release;
        !bus_grant_n |-> ##[0:1] !cpuBusOe;
    endproperty
    a_release: assert property (p_release)
        else $error("grant without releasing the bus");
    property p_one_driver;
        !(cpuBusOe && agentBusOe);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the bus");
    property p_cpu_valid;
        !cpu_valid_strobe_n |-> cpuBusOe;
    endproperty
    a_cpu_valid: assert property (p_cpu_valid)
        else $error("cpu strobe while not driving");
    property p_agent_valid;
        !agent_valid_strobe_n |-> agentBusOe && !cpuBusOe;
    endproperty
    a_agent_valid: assert property (p_agent_valid)
        else $error("agent strobe outside slave state");
    property p_self_release;
        readAddr ##1 !readAddr |-> !bus_grant_n;
    endproperty
    a_self_release: assert property (p_self_release)
        else $error("no grant after read issue");
    property p_one_read;
        readAddr |-> !pendingQ;
    endproperty
    a_one_read: assert property (p_one_read)
        else $error("second read while one is pending");
    property p_cmd_code;
        !cpu_valid_strobe_n |-> (cpuCommand[8] ? cpuCommand[7:0] == DATA_ID_LAST
            : cpuCommand[7:0] == CMD_READ || cpuCommand[7:0] == CMD_WRITE);
    endproperty
    a_cmd_code: assert property (p_cmd_code)
        else $error("bad command on a valid cycle");
    property p_data_after_addr;
        !cpu_valid_strobe_n && cpuCommand[8] |-> !$past(cpu_valid_strobe_n)
            && $past(cpuCommand) == {1'b0, CMD_WRITE};
    endproperty
    a_data_after_addr: assert property (p_data_after_addr)
        else $error("write data not after its address");
    property p_back_to_master;
        $fell(cpuBusOe) |-> ##[1:64] cpuBusOe;
    endproperty
    a_back_to_master: assert property (p_back_to_master)
        else $error("bus not returned to the processor");
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench: processor end and agent end joined by csb_if.
// Assumes a 250 MHz clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import csb_pkg::*;
    localparam int LIMIT = 20000;
    logic clk = 1'b0, arst_n = 1'b0, legacyMode = 1'b0, reqValid = 1'b0;
    logic reqIsWrite = 1'b0, canRead = 1'b1, canWrite = 1'b1;
    logic extReqValid = 1'b0, respError = 1'b0, wrPend = 1'b0;
    logic [63:0] reqAddr = 64'h0, reqWriteData = 64'h0, extReqAddr = 64'h0;
    logic [63:0] respData = 64'h0, expRead = 64'h0, readData, cpuReqWord;
    logic reqReady, readDoneValid, busError, extReqDone, cpuReqValid;
    logic [8:0] cpuReqCmd;
    logic [72:0] cpuQ[$];
    logic [72:0] lastSeen = 73'h0;
    int failures = 0, checked = 0, cycles = 0, wrEnd = 0;
    int nRead = 0, nErr = 0, nExt = 0, readBase = 0, errBase = 0;
    integer seed = 32'h9b3c81d9;
    csb_if bus();
    csb_cpu_end i_csb_cpu_end (.clk(clk), .arst_n(arst_n), .bus(bus.cpu),
        .legacyMode(legacyMode), .reqValid(reqValid), .reqIsWrite(reqIsWrite),
        .reqAddr(reqAddr), .reqWriteData(reqWriteData), .reqReady(reqReady),
        .readDoneValid(readDoneValid), .readData(readData),
        .busError(busError));
    csb_agent_end i_csb_agent_end (.clk(clk), .arst_n(arst_n),
        .bus(bus.agent), .canRead(canRead), .canWrite(canWrite),
        .extReqValid(extReqValid), .extReqAddr(extReqAddr),
        .respData(respData), .respError(respError), .extReqDone(extReqDone),
        .cpuReqValid(cpuReqValid), .cpuReqWord(cpuReqWord),
        .cpuReqCmd(cpuReqCmd));
    csb_bus_props i_csb_bus_props (.clk(clk), .arst_n(arst_n),
        .cpuCommand(bus.cpuCommand), .cpuBusOe(bus.cpuBusOe),
        .agentCommand(bus.agentCommand), .agentBusOe(bus.agentBusOe),
        .cpu_valid_strobe_n(bus.cpu_valid_strobe_n),
        .agent_valid_strobe_n(bus.agent_valid_strobe_n),
        .bus_grant_n(bus.bus_grant_n));
    // Free-running clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // Result monitor and wire watch, against queued expectations
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("BAD %0t run too long", $time);
            print_verdict();
        end
        if (arst_n) begin
            if (readDoneValid === 1'b1) begin
                nRead++;
                check(readData === expRead, "read data");
            end
            if (busError === 1'b1) nErr++;
            if (extReqDone === 1'b1) nExt++;
            if (cpuReqValid === 1'b1 && {cpuReqCmd, cpuReqWord} !== lastSeen) begin
                lastSeen = {cpuReqCmd, cpuReqWord};
                check(cpuQ.size() > 0 && lastSeen === cpuQ[0], "cycle");
                if (cpuQ.size() > 0) void'(cpuQ.pop_front());
            end
            if (bus.cpu_valid_strobe_n === 1'b0) begin
                if (bus.cpuCommand[8] === 1'b1) begin
                    wrEnd = cycles;
                    wrPend = 1'b1;
                end else if (wrPend) begin
                    wrPend = 1'b0;
                    if (legacyMode) begin
                        check(cycles - wrEnd >= 4, "write spacing");
                    end
                end
            end
        end
    end
    task automatic cpu_req(input bit wr, input logic [63:0] a, d);
        int n;
        @(negedge clk);
        for (n = 0; n < 400 && reqReady !== 1'b1; n++) @(negedge clk);
        reqValid = 1'b1;
        reqIsWrite = wr;
        reqAddr = a;
        reqWriteData = d;
        cpuQ.push_back({1'b0, wr ? CMD_WRITE : CMD_READ, a});
        if (wr) cpuQ.push_back({1'b1, DATA_ID_LAST, d});
        @(negedge clk);
        reqValid = 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        repeat (2) @(negedge clk);
        for (n = 0; n < 400 && !(reqReady === 1'b1 && cpuQ.size() == 0); n++)
            @(negedge clk);
    endtask
    task automatic do_write();
        cpu_req(1'b1, {$random(seed), $random(seed)}, {$random(seed), 32'h5});
        wait_idle();
        check(cpuQ.size() == 0, "write lost");
    endtask
    task automatic start_read(input bit err);
        readBase = nRead;
        errBase = nErr;
        expRead = {$random(seed), $random(seed)};
        respData = expRead;
        respError = err;
        cpu_req(1'b0, {$random(seed), $random(seed)}, 64'h0);
    endtask
    task automatic end_read(input bit err);
        int n;
        for (n = 0; n < 400 && nRead == readBase && nErr == errBase; n++)
            @(negedge clk);
        repeat (4) @(negedge clk);
        check(nRead + nErr > readBase + errBase, "read unfinished");
        check(nErr - errBase == int'(err), "error flag");
        respError = 1'b0;
    endtask
    task automatic do_ext();
        int eb;
        int n;
        eb = nExt;
        extReqAddr = {$random(seed), $random(seed)};
        extReqValid = 1'b1;
        for (n = 0; n < 400 && nExt == eb; n++) @(negedge clk);
        extReqValid = 1'b0;
        check(nExt == eb + 1, "external unfinished");
        repeat (4) @(negedge clk);
        check(bus.cpuBusOe === 1'b1, "bus not back");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        for (int m = 0; m < 2; m++) begin
            legacyMode = m[0];
            repeat (8) @(negedge clk);
            for (int i = 0; i < 10; i++) begin
                if ($random(seed) & 1) begin
                    do_write();
                end else begin
                    start_read(1'b0);
                    end_read(1'b0);
                end
            end
            repeat (3) do_write();
        end
        start_read(1'b1);
        end_read(1'b1);
        canRead = 1'b0;
        start_read(1'b0);
        repeat (40) @(negedge clk);
        check(nRead == readBase, "read without ready");
        canRead = 1'b1;
        end_read(1'b0);
        canWrite = 1'b0;
        cpu_req(1'b1, {$random(seed), $random(seed)}, {$random(seed), 32'h9});
        repeat (20) @(negedge clk);
        check(cpuQ.size() == 1, "write data before issue");
        do_ext();
        canWrite = 1'b1;
        wait_idle();
        check(cpuQ.size() == 0, "write lost after handover");
        do_ext();
        start_read(1'b0);
        repeat (3) @(negedge clk);
        arst_n = 1'b0;
        cpuQ.delete();
        lastSeen = 73'h0;
        wrPend = 1'b0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        start_read(1'b0);
        end_read(1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
